/* File: led_latch_pkg.sv */
package led_latch_pkg;

    localparam int          CH_COUNT      = 8;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          STAGGER_NS    = 17;
    localparam int          STAGGER_TOTAL_NS = 120;
    // The step delay rounds down, but never below one cycle.
    localparam int          STAGGER_CYC   = (STAGGER_NS / CLK_PERIOD_NS) < 1 ? 1
                                            : (STAGGER_NS / CLK_PERIOD_NS);
    localparam int          BUF_DEPTH     = 2;
    localparam logic [7:0]  SHIFT_RST     = 8'h00;
    localparam logic [7:0]  LATCH_RST     = 8'h00;
    localparam logic [7:0]  CHAN_RST      = 8'h00;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN  = 2'b10
    } seq_state_e;

endpackage

/* File: serial_led_channel_latch.sv */
`timescale 1ns/10ps
// How it works
// (R1) An eight-stage shift chain and a separate eight-bit output latch hold one bit per channel.
// (R2) Each rising serial clock edge shifts the chain one stage and takes serial_in into stage one.
// (R3) serial_out is driven from the last stage so devices can be cascaded.
// (R4) The host clocks in one bit per serial clock, eight bits per cascaded device.
// (R5) While latch is high the output latch follows the shift chain; the code holds it instead while the two-entry buffer is full.
// (R6) On the latch falling edge the latch keeps the chain value and ignores later shifting.
// (R7) Each latch bit decides whether its own channel is on or off.
// (R8) While blank is low every channel follows its latch bit.
// (R9) While blank is high all channels sink nothing but the latch keeps its contents.
// (R10) Power-up reset clears the chain and the latch and turns every channel off.
// (R11) The host waits for the end of power-up reset before programming.
// (R12) Each channel changes a fixed step after the one before it.
// (R13) The stagger starts on a latch update and applies to both turn-on and turn-off.
// (R14) Undriven blank reads as disabling and undriven latch as inactive.
// (R15) Stage n feeds latch bit n and channel n; the first bit shifted ends in stage eight.
// (R16) A latch bit of one turns its channel on and zero turns it off.
module serial_led_channel_latch
    import led_latch_pkg::*;
#(
    parameter int N_CH       = CH_COUNT,
    parameter int STEP_CYC   = STAGGER_CYC
) (
    input  wire logic            sys_clk,         // 40 MHz system clock
    input  wire logic            rstn,            // Power-up lockout, active low
    input  wire logic            serial_clk,      // Serial clock pin
    input  wire logic            serial_in,       // Serial data pin
    input  wire logic            latch_in,        // Latch pin, pulled low when open
    input  wire logic            blank_in,        // Blank pin, pulled high when open
    output logic                 serial_out,      // Cascade data out
    output logic [N_CH-1:0]      channel_outputs  // High while the channel sinks current
);

    localparam int CW = $clog2(STEP_CYC + 1) + 1;
    localparam int IW = $clog2(N_CH) + 1;

    logic              rst_s1_r, rst_n_r;
    logic [1:0]        sck_s1_r, sck_s1_nxt;
    logic              sck_s2_r, sck_s2_nxt;
    logic              sck_d_r, sck_d_nxt;
    logic [1:0]        din_s_r, din_s_nxt;
    logic [1:0]        lat_s_r, lat_s_nxt;
    logic [1:0]        blk_s_r, blk_s_nxt;
    logic [N_CH-1:0]   shift_stages_r, shift_stages_nxt;
    logic [N_CH-1:0]   latch_bits_r, latch_bits_nxt;
    logic [N_CH-1:0]   pushed_r, pushed_nxt;
    logic [N_CH-1:0]   buf_mem_r [BUF_DEPTH];
    logic [N_CH-1:0]   buf_mem_nxt [BUF_DEPTH];
    logic              buf_wp_r, buf_wp_nxt, buf_rp_r, buf_rp_nxt;
    logic [1:0]        buf_cnt_r, buf_cnt_nxt;
    logic              in_valid, in_ready, out_valid, out_ready;
    seq_state_e        seq_r, seq_nxt;
    logic [N_CH-1:0]   word_r, word_nxt;
    logic [IW-1:0]     ch_r, ch_nxt;
    logic [CW-1:0]     cnt_r, cnt_nxt;
    logic [N_CH-1:0]   chan_state_r, chan_state_nxt;
    logic [N_CH-1:0]   chan_out_r, chan_out_nxt;
    logic              sck_rise;

    // Reset release through two flops; assertion stays asynchronous.
    // Every other flop leaves reset on the same edge, so no stage starts a cycle early.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // Pin synchronisers. Blank resets to its disabling level, latch to inactive.
    // Only the second flop of each pair is read by logic; the serial clock gets one
    // extra stage so that its edge is seen after the data copy has settled.
    always_comb begin
        sck_s1_nxt = {sck_s1_r[0], serial_clk};
        sck_s2_nxt = sck_s1_r[1];
        sck_d_nxt  = sck_s2_r;
        din_s_nxt  = {din_s_r[0], serial_in};
        lat_s_nxt  = {lat_s_r[0], latch_in};
        blk_s_nxt  = {blk_s_r[0], blank_in};
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sck_s1_r <= 2'h0;
            sck_s2_r <= 1'b0;
            sck_d_r  <= 1'b0;
            din_s_r  <= 2'h0;
            lat_s_r  <= 2'h0;                              // [R14]
            blk_s_r  <= 2'h3;                              // [R14]
        end else begin
            sck_s1_r <= sck_s1_nxt;
            sck_s2_r <= sck_s2_nxt;
            sck_d_r  <= sck_d_nxt;
            din_s_r  <= din_s_nxt;
            lat_s_r  <= lat_s_nxt;
            blk_s_r  <= blk_s_nxt;
        end
    end

    // The clock path is one stage longer so data is sampled mid-bit. The serial
    // clock must stay at each level for at least three system clocks.
    // Shorter levels may be missed altogether rather than shifted twice.
    assign sck_rise = sck_s2_r & ~sck_d_r;

    // Shift chain and output latch.
    always_comb begin
        shift_stages_nxt = shift_stages_r;
        if (sck_rise) begin
            shift_stages_nxt = {shift_stages_r[N_CH-2:0], din_s_r[1]};  // [R2] [R15]
        end
        latch_bits_nxt = latch_bits_r;                     // [R6]
        if (lat_s_r[1] && in_ready) begin
            latch_bits_nxt = shift_stages_nxt;             // [R5] [R15]
        end
    end

    // Two-entry buffer between the latch and the stagger sequencer. A word is
    // offered whenever the latch differs from the last word queued; when full,
    // the latch holds off following the chain until room appears.
    // If the buffer is still full when latch falls, the held value is the last one
    // that could be queued; a host must not latch faster than the stagger drains.
    assign in_valid  = (latch_bits_r != pushed_r);
    assign in_ready  = (buf_cnt_r != 2'(BUF_DEPTH));
    assign out_valid = (buf_cnt_r != 2'h0);
    assign out_ready = (seq_r == SEQ_IDLE);

    always_comb begin
        buf_mem_nxt = buf_mem_r;
        buf_wp_nxt  = buf_wp_r;
        buf_rp_nxt  = buf_rp_r;
        buf_cnt_nxt = buf_cnt_r;
        pushed_nxt  = pushed_r;
        if (in_valid && in_ready) begin
            buf_mem_nxt[buf_wp_r] = latch_bits_r;
            buf_wp_nxt  = ~buf_wp_r;
            pushed_nxt  = latch_bits_r;
        end
        if (out_valid && out_ready) begin
            buf_rp_nxt = ~buf_rp_r;
        end
        buf_cnt_nxt = buf_cnt_r + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
    end

    // Stagger sequencer: channel k takes its new state k steps after the first.
    // With the default step of one cycle the eighth channel lags the first by seven
    // cycles, which keeps the inrush spread without any long counter.
    always_comb begin
        seq_nxt        = seq_r;
        word_nxt       = word_r;
        ch_nxt         = ch_r;
        cnt_nxt        = cnt_r;
        chan_state_nxt = chan_state_r;
        case (seq_r)
            SEQ_IDLE: begin
                if (out_valid) begin                       // [R13]
                    word_nxt = buf_mem_r[buf_rp_r];
                    ch_nxt   = '0;
                    cnt_nxt  = '0;
                    seq_nxt  = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (cnt_r == '0) begin
                    chan_state_nxt[ch_r[IW-2:0]] = word_r[ch_r[IW-2:0]];  // [R7] [R13]
                    if (ch_r == IW'(N_CH - 1)) begin
                        seq_nxt = SEQ_IDLE;
                    end else begin
                        ch_nxt  = ch_r + 1'b1;
                        cnt_nxt = CW'(STEP_CYC - 1);       // [R12]
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;                // [R12]
                end
            end
            default: seq_nxt = SEQ_IDLE;
        endcase
    end

    // Blank gates the drivers only; the latched state is untouched, so channels
    // come back at once when blank drops, without a second stagger.
    always_comb begin
        chan_out_nxt = blk_s_r[1] ? '0 : chan_state_r;    // [R8] [R9] [R16]
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            shift_stages_r <= SHIFT_RST;                   // [R10]
            latch_bits_r   <= LATCH_RST;                   // [R10]
            pushed_r       <= LATCH_RST;
            buf_mem_r      <= '{default: '0};
            buf_wp_r       <= 1'b0;
            buf_rp_r       <= 1'b0;
            buf_cnt_r      <= 2'h0;
            seq_r          <= SEQ_IDLE;
            word_r         <= '0;
            ch_r           <= '0;
            cnt_r          <= '0;
            chan_state_r   <= CHAN_RST;                    // [R10]
            chan_out_r     <= CHAN_RST;                    // [R10]
        end else begin
            shift_stages_r <= shift_stages_nxt;
            latch_bits_r   <= latch_bits_nxt;
            pushed_r       <= pushed_nxt;
            buf_mem_r      <= buf_mem_nxt;
            buf_wp_r       <= buf_wp_nxt;
            buf_rp_r       <= buf_rp_nxt;
            buf_cnt_r      <= buf_cnt_nxt;
            seq_r          <= seq_nxt;
            word_r         <= word_nxt;
            ch_r           <= ch_nxt;
            cnt_r          <= cnt_nxt;
            chan_state_r   <= chan_state_nxt;
            chan_out_r     <= chan_out_nxt;
        end
    end

    assign serial_out      = shift_stages_r[N_CH-1];      // [R3] [R1]
    assign channel_outputs = chan_out_r;

endmodule // serial_led_channel_latch

/* File: led_host_model.sv */
`timescale 1ns/10ps
module led_host_model (
    input  wire logic sys_clk,    // System clock
    output logic      serial_clk, // Serial clock pin
    output logic      serial_in,  // Serial data pin
    output logic      latch_in,   // Latch pin
    output logic      blank_in    // Blank pin
);
    // Pins start at their pulled levels until the host takes them over.
    initial begin
        serial_clk = 1'b0;
        serial_in  = 1'b0;
        latch_in   = 1'b0;
        blank_in   = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // The serial clock stands still between frames.
    task automatic shift_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            serial_in = w[i];
            tk(2);
            serial_clk = 1'b1;
            tk(4);
            serial_clk = 1'b0;
            tk(2);
        end
        // A released data line shows the inverse, so stale data never passes for new.
        serial_in = ~w[0];
    endtask
    task automatic latch_pulse();
        latch_in = 1'b1;
        tk(4);
        latch_in = 1'b0;
    endtask
    task automatic set_blank(input logic b);
        blank_in = b;
    endtask
endmodule // led_host_model

/* File: led_latch_sva.sv */
`timescale 1ns/10ps
module led_latch_sva #(
    parameter int N_CH = 8
) (
    input wire logic            sys_clk,        // Clock
    input wire logic            rstn,           // Reset, active low
    input wire logic            serial_clk,     // Serial clock
    input wire logic            serial_in,      // Serial data
    input wire logic            latch_in,       // Latch
    input wire logic            blank_in,       // Blank
    input wire logic            serial_out,     // Cascade out
    input wire logic [N_CH-1:0] channel_outputs // Channels
);
    logic [N_CH-1:0] sh_r;
    logic [N_CH-1:0] ls_r;
    logic [4:0]      q_r;
    logic            sck_p_r;
    logic            blk_p_r;
    // Shadow chain and latch; q_r counts cycles since latch or blank activity.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sh_r <= '0;
            ls_r <= '0;
            q_r  <= 5'h00;
            sck_p_r <= 1'b0;
            blk_p_r <= 1'b1;
        end else begin
            sck_p_r <= serial_clk;
            blk_p_r <= blank_in;
            if (serial_clk && !sck_p_r) sh_r <= {sh_r[N_CH-2:0], serial_in};
            if (latch_in) ls_r <= sh_r;
            q_r <= (latch_in || (blank_in != blk_p_r)) ? 5'h00 : q_r + {4'h0, q_r != 5'h1F};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_reset_clears: assert property ($rose(rstn) |-> channel_outputs == '0 && !serial_out)
        else $error("outputs not clear after reset");
    a_shift_out: assert property ($rose(serial_clk) |-> ##6 serial_out == sh_r[N_CH-1])
        else $error("serial_out not last stage");
    a_latch_follow: assert property ($rose(latch_in) |-> ##16 (blank_in || channel_outputs == ls_r))
        else $error("channels do not show latch");
    a_latch_hold: assert property (q_r > 5'h13 && !blank_in |-> channel_outputs == ls_r)
        else $error("channels moved without latch");
    a_stagger_single: assert property ((!blank_in)[*8] |-> $onehot0(channel_outputs ^ $past(channel_outputs)))
        else $error("channels switched together");
    a_stagger_span: assert property ($rose(latch_in) |-> ##1 $stable(channel_outputs[N_CH-1])[*6])
        else $error("last channel switched early");
    a_blank_off: assert property (blank_in[*5] |-> channel_outputs == '0)
        else $error("channel on while blanked");
    a_blank_restore: assert property ($fell(blank_in) |-> ##6 channel_outputs == ls_r)
        else $error("channels not restored");
    c_latch: cover property ($rose(latch_in));
    c_unblank: cover property ($fell(blank_in));
    c_shift: cover property ($rose(serial_clk) ##6 serial_out);
endmodule // led_latch_sva

/* File: serial_led_channel_latch_tb_top.sv */
`timescale 1ns/10ps
module serial_led_channel_latch_tb_top;
    import led_latch_pkg::*;
    logic                sys_clk, rstn, serial_clk, serial_in, latch_in, blank_in, serial_out;
    logic [CH_COUNT-1:0] channel_outputs;
    int                  n_fail = 0;
    int                  total_checks = 0;
    serial_led_channel_latch uut (.sys_clk(sys_clk), .rstn(rstn), .serial_clk(serial_clk),
        .serial_in(serial_in), .latch_in(latch_in), .blank_in(blank_in),
        .serial_out(serial_out), .channel_outputs(channel_outputs));
    led_host_model host (.sys_clk(sys_clk), .serial_clk(serial_clk), .serial_in(serial_in),
        .latch_in(latch_in), .blank_in(blank_in));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic results();
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp=%h got=%h", nm, exp, got);
        end
    endtask
    task automatic t_stagger();
        int n;
        host.shift_word(8'hFF);
        host.latch_pulse();
        n = 0;
        while (channel_outputs === 8'h00 && n < 40) begin
            host.tk(1);
            n++;
        end
        if (n == 40) begin
            n_fail++;
            results();
        end
        for (int k = 0; k < 8; k++) begin
            chk("stagger", channel_outputs, 8'((9'h1 << (k + 1)) - 9'h1));
            host.tk(STAGGER_CYC);
        end
    endtask
    task automatic t_words();
        logic [7:0] w [4] = '{8'h96, 8'h00, 8'h3C, 8'hA5};
        foreach (w[i]) begin
            host.shift_word(w[i]);
            host.latch_pulse();
            host.tk(24);
            chk("latched", channel_outputs, w[i]);
        end
    endtask
    task automatic t_hold_blank();
        host.shift_word(8'h5A);
        host.tk(4);
        chk("hold", channel_outputs, 8'hA5);
        chk("cascade", {7'h00, serial_out}, 8'h00);
        host.set_blank(1'b1);
        host.tk(8);
        chk("blanked", channel_outputs, 8'h00);
        host.set_blank(1'b0);
        host.tk(8);
        chk("restored", channel_outputs, 8'hA5);
        host.latch_pulse();
        host.tk(24);
        chk("relatched", channel_outputs, 8'h5A);
    endtask
    task automatic t_reset();
        host.shift_word(8'hFF);
        chk("cascade_one", {7'h00, serial_out}, 8'h01);
        rstn = 1'b0;
        host.tk(3);
        rstn = 1'b1;
        host.tk(4);
        chk("reset_out", channel_outputs, 8'h00);
        chk("reset_chain", {7'h00, serial_out}, 8'h00);
    endtask
    initial begin
        rstn = 1'b0;
        repeat (3) @(posedge sys_clk);
        #2;
        rstn = 1'b1;
        host.tk(4);
        chk("reset", channel_outputs, 8'h00);
        host.set_blank(1'b0);
        t_stagger();
        t_words();
        t_hold_blank();
        t_reset();
        results();
    end
endmodule // serial_led_channel_latch_tb_top
bind serial_led_channel_latch led_latch_sva #(.N_CH(N_CH)) chk_i (.sys_clk(sys_clk),
    .rstn(rstn), .serial_clk(serial_clk), .serial_in(serial_in), .latch_in(latch_in),
    .blank_in(blank_in), .serial_out(serial_out), .channel_outputs(channel_outputs));
